// file: design/pzsp_pkg.sv
package pzsp_pkg;

    // wide organisation: four lanes of eight data bits plus one parity bit
    localparam int ADDR_W     = 19;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = LANES * LANE_W;
    localparam int MEM_DEPTH  = 1 << ADDR_W;
    localparam int BURST_W    = 2;
    localparam int BASE_W     = ADDR_W - BURST_W;

    // sleep entry comes from the two-stage synchroniser, wake-up from a counter
    localparam logic [1:0] WAKE_CYCLES = 2'h2;
    localparam logic [1:0] WAKE_DONE   = 2'h0;

    // reset values of the pipeline
    localparam logic [DATA_W-1:0] DATA_RESET  = 36'h000000000;
    localparam logic [ADDR_W-1:0] ADDR_RESET  = 19'h00000;
    localparam logic [LANES-1:0]  LANE_NONE   = 4'h0;
    localparam logic [BURST_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BURST_W-1:0] BEAT_STEP  = 2'h1;

    typedef enum logic [1:0] {
        PZSP_DESEL = 2'b00,
        PZSP_READ  = 2'b01,
        PZSP_WRITE = 2'b10
    } pzsp_state_t;

    // replace the lanes selected by mask with the new word
    function automatic logic [DATA_W-1:0] mergeLanes(
        input logic [DATA_W-1:0] oldWord,
        input logic [DATA_W-1:0] newWord,
        input logic [LANES-1:0]  mask
    );
        logic [DATA_W-1:0] res;
        res = oldWord;
        for (int i = 0; i < LANES; i++) begin
            if (mask[i]) begin
                res[i*LANE_W +: LANE_W] = newWord[i*LANE_W +: LANE_W];
            end
        end
        return res;
    endfunction

endpackage

// file: design/pzsp_burst_if.sv
`timescale 1ns/1ns
interface pzsp_burst_if;
    import pzsp_pkg::*;

    logic               load;
    logic               advance;
    logic [BURST_W-1:0] startBits;
    logic               orderSel;
    logic [BURST_W-1:0] lowBits;

    modport ctrl (
        output load,
        output advance,
        output startBits,
        output orderSel,
        input  lowBits
    );

    modport gen (
        input  load,
        input  advance,
        input  startBits,
        input  orderSel,
        output lowBits
    );
endinterface

// file: design/pzsp_burst_gen.sv
`timescale 1ns/1ns
module pzsp_burst_gen
    import pzsp_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    pzsp_burst_if.gen   bus
);

    logic [BURST_W-1:0] start_q;
    logic [BURST_W-1:0] beat_q;

    // seed on load, step on advance; two bits wrap after four beats
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= BEAT_FIRST;
            beat_q  <= BEAT_FIRST;
        end else if (bus.load) begin
            start_q <= bus.startBits;
            beat_q  <= BEAT_FIRST;
        end else if (bus.advance) begin
            beat_q  <= beat_q + BEAT_STEP;
        end
    end

    // interleaved flips bits, linear adds modulo four
    assign bus.lowBits = bus.orderSel ? (start_q ^ beat_q)
                                      : (start_q + beat_q);

endmodule // pzsp_burst_gen

// file: design/pzsp_port.sv
`timescale 1ns/1ns
// Summary of operation
// - inputs sampled on rising edge, except async ones
// - clock enable high freezes every register except the sleep and order synchronisers
// - load, all selects active starts an operation
// - load without selection deselects; deselect continues
// - read data registered, driven from second edge
// - output enable high makes read a dummy
// - output enable cuts drivers asynchronously
// - write data taken two edges after command
// - byte lanes written per low byte-write
// - reads and writes follow with no gap
// - advance continues; two-bit counter wraps four
// - order low gives linear modulo-four sequence
// - order high gives start XOR beat count
// - sleep taken two cycles after request, state kept
// - two wake-up cycles after sleep release
// - two low address bits seed burst counter
// - sleep or deselect keeps data pins released
module pzsp_port
    import pzsp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clkEnN,
    input  wire logic              loadAdvanceN,
    input  wire logic              chipSelAN,
    input  wire logic              chipSelB,
    input  wire logic              chipSelCN,
    input  wire logic              writeEnN,
    input  wire logic [LANES-1:0]  byteWriteN,
    input  wire logic              outEnN,
    input  wire logic              burstOrderSel,
    input  wire logic              sleepReq,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dataIn,
    output logic      [DATA_W-1:0] dataOut,
    output logic                   dataOe,
    output logic                   sleeping,
    output logic                   awake
);


    // asynchronous and static pins
    // both may change with no relation to the clock
    // a single flop could go metastable and feed
    // half the pipeline one value, half the other
    // so only the second stage is ever read

    logic              sleepMeta_q;
    logic              sleepSync_q;
    logic              orderMeta_q;
    logic              orderSync_q;

    // sleep and burst order pass two flops; the two stages also give the
    // entry delay, so no separate sleep counter is needed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepMeta_q <= 1'b0;
            sleepSync_q <= 1'b0;
            orderMeta_q <= 1'b0;
            orderSync_q <= 1'b0;
        end else begin
            sleepMeta_q <= sleepReq;
            sleepSync_q <= sleepMeta_q;
            orderMeta_q <= burstOrderSel;
            orderSync_q <= orderMeta_q;
        end
    end


    // wake-up and clock-enable gating
    // a single run strobe gates every pipeline flop
    // so clock enable, sleep and wake-up cannot
    // disagree about which edges count

    logic [1:0]        wakeCnt_q;
    logic [1:0]        wakeCnt_d;
    logic              wakeDone;
    logic              run;

    // counter reloads while asleep and drains once the pin is low again
    assign wakeCnt_d = sleepSync_q ? WAKE_CYCLES :
                       (wakeCnt_q != WAKE_DONE) ? wakeCnt_q - 2'h1 :
                       WAKE_DONE;
    assign wakeDone  = (wakeCnt_q == WAKE_DONE);

    // one enable for every pipeline register; sleep freezes it too,
    // which is how internal state survives the power-down
    assign run = ~clkEnN & ~sleepSync_q & wakeDone;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeCnt_q <= WAKE_DONE;
        end else if (!clkEnN) begin
            wakeCnt_q <= wakeCnt_d;
        end
    end


    // command decode
    // pure decode of the sampled pins; gating by run
    // happens at the registers, not here

    logic              selected;
    logic              loadCmd;
    logic              startOp;
    logic              deselOp;
    logic [LANES-1:0]  laneEn;

    assign selected = ~chipSelAN & chipSelB & ~chipSelCN;
    assign loadCmd  = ~loadAdvanceN;
    assign startOp  = loadCmd & selected;
    assign deselOp  = loadCmd & ~selected;
    assign laneEn   = ~byteWriteN;


    // operation state
    // three states are enough: the burst counter keeps
    // the beat position, the state only says what kind
    // of beat the next advance continues

    pzsp_state_t       state_q;
    pzsp_state_t       state_d;

    // advance keeps whatever is running; a deselect can only be continued
    // from a deselect, so a fresh load is the only way back out
    always_comb begin
        case (state_q)
            PZSP_DESEL: begin
                if (startOp) begin
                    state_d = writeEnN ? PZSP_READ : PZSP_WRITE;
                end else begin
                    state_d = PZSP_DESEL;
                end
            end
            PZSP_READ: begin
                if (deselOp) begin
                    state_d = PZSP_DESEL;
                end else if (startOp) begin
                    state_d = writeEnN ? PZSP_READ : PZSP_WRITE;
                end else begin
                    state_d = PZSP_READ;
                end
            end
            PZSP_WRITE: begin
                if (deselOp) begin
                    state_d = PZSP_DESEL;
                end else if (startOp) begin
                    state_d = writeEnN ? PZSP_READ : PZSP_WRITE;
                end else begin
                    state_d = PZSP_WRITE;
                end
            end
            default: begin
                state_d = PZSP_DESEL;
            end
        endcase
    end


    // address capture and burst generation
    // upper bits are held from the load edge; only the
    // two low bits move, inside the burst generator
    // limitation: bursts never carry into the upper bits

    pzsp_burst_if      burstBus ();

    logic [BASE_W-1:0] baseHi_q;
    logic [LANES-1:0]  laneEn_q;
    logic [ADDR_W-1:0] curAddr;

    assign burstBus.load      = run & startOp;
    assign burstBus.advance   = run & ~loadCmd & (state_q != PZSP_DESEL);
    assign burstBus.startBits = addr[BURST_W-1:0];
    assign burstBus.orderSel  = orderSync_q;

    pzsp_burst_gen u_burst (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (burstBus.gen)
    );

    // word address of the beat in progress
    assign curAddr = {baseHi_q, burstBus.lowBits};

    // state, upper address and per-beat lane enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= PZSP_DESEL;
            baseHi_q <= ADDR_RESET[ADDR_W-1:BURST_W];
            laneEn_q <= LANE_NONE;
        end else if (run) begin
            state_q  <= state_d;
            laneEn_q <= laneEn;
            if (startOp) begin
                baseHi_q <= addr[ADDR_W-1:BURST_W];
            end
        end
    end


    // late-late write pipeline
    // one stage of address and mask is enough: a new
    // beat may enter every edge, and each leaves two
    // edges after its command, when its data arrives

    logic              readBeat;
    logic              writeBeat;
    logic [ADDR_W-1:0] pendAddr_q;
    logic [LANES-1:0]  pendMask_q;
    logic              pendValid_q;

    assign readBeat  = (state_q == PZSP_READ);
    // all lanes off makes the beat a no-op and nothing is queued
    assign writeBeat = (state_q == PZSP_WRITE) & (laneEn_q != LANE_NONE);

    // the beat registered at the command edge moves here at the next
    // edge, and its data is consumed at the edge after that
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pendAddr_q  <= ADDR_RESET;
            pendMask_q  <= LANE_NONE;
            pendValid_q <= 1'b0;
        end else if (run) begin
            pendAddr_q  <= curAddr;
            pendMask_q  <= laneEn_q;
            pendValid_q <= writeBeat;
        end
    end


    // storage array
    // not reset: contents are unknown until written
    // one write port and one read port per edge

    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [DATA_W-1:0] memWord;
    logic              fwdHit;
    logic [DATA_W-1:0] rdWord;

    // data on the pins this edge belongs to the write two edges back
    always_ff @(posedge clk) begin
        if (run && pendValid_q) begin
            mem[pendAddr_q] <= mergeLanes(mem[pendAddr_q], dataIn, pendMask_q);
        end
    end

    // the only write still in flight during a read beat is the one whose
    // data lands at the same edge the read result is captured, so it can
    // be merged straight from the data pins
    assign memWord = mem[curAddr];
    assign fwdHit  = pendValid_q & (pendAddr_q == curAddr);
    assign rdWord  = fwdHit ? mergeLanes(memWord, dataIn, pendMask_q)
                            : memWord;


    // output register and drivers
    // data comes from a flop so it is stable for the
    // whole cycle; only the enable is combinational
    // trade-off: output enable reaches the pins with no
    // clock delay, at the cost of an ungated input path

    logic [DATA_W-1:0] rdData_q;
    logic              drive_q;

    // array read between edges, captured on the second edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= DATA_RESET;
            drive_q  <= 1'b0;
        end else if (run) begin
            drive_q  <= readBeat;
            if (readBeat) begin
                rdData_q <= rdWord;
            end
        end
    end

    // output enable is not registered: it gates the drivers at any time,
    // so a read beat with it high is just a dummy read
    assign dataOut  = rdData_q;
    assign dataOe   = drive_q & ~outEnN & ~sleepSync_q;

    // status for the surrounding logic
    assign sleeping = sleepSync_q;
    assign awake    = ~sleepSync_q & wakeDone;

endmodule // pzsp_port

// file: verification/pzsp_port_props.sv
`timescale 1ns/1ns
module pzsp_port_chk
    import pzsp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clkEnN,
    input  wire logic              loadAdvanceN,
    input  wire logic              chipSelAN,
    input  wire logic              chipSelB,
    input  wire logic              chipSelCN,
    input  wire logic              writeEnN,
    input  wire logic              outEnN,
    input  wire logic              sleepReq,
    input  wire logic [DATA_W-1:0] dataOut,
    input  wire logic              dataOe,
    input  wire logic              sleeping,
    input  wire logic              awake
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // a run edge is one the port acts on; a load edge also has load/advance low
    wire run = !clkEnN && awake && !sleeping;
    wire ld  = run && !loadAdvanceN;
    wire sel = !chipSelAN && chipSelB && !chipSelCN;

    property p_oe_cut; outEnN |-> !dataOe; endproperty
    a_oe_cut: assert property (p_oe_cut) else $error("drive with output enable off");
    property p_sleep_hiz; sleeping |-> !dataOe; endproperty
    a_sleep_hiz: assert property (p_sleep_hiz) else $error("drive while asleep");
    property p_desel_hiz; ld && !sel ##1 run |=> !dataOe; endproperty
    a_desel_hiz: assert property (p_desel_hiz) else $error("drive after deselect");
    property p_write_hiz; ld && sel && !writeEnN ##1 run |=> !dataOe; endproperty
    a_write_hiz: assert property (p_write_hiz) else $error("drive after write start");
    property p_read_lat;
        ld && sel && writeEnN && !sleepReq ##1 run |=> dataOe == !outEnN;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data not driven");
    property p_freeze; clkEnN |=> $stable(dataOut); endproperty
    a_freeze: assert property (p_freeze) else $error("output moved on ignored edge");
    property p_sleep_in; !sleeping && $rose(sleepReq) ##1 sleepReq |=> sleeping; endproperty
    a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
    property p_sleep_late; !sleeping && $rose(sleepReq) |=> !sleeping; endproperty
    a_sleep_late: assert property (p_sleep_late) else $error("sleep entered early");
    property p_wake; $fell(sleeping) ##0 !clkEnN [*2] |-> !awake ##1 awake; endproperty
    a_wake: assert property (p_wake) else $error("wake-up count wrong");
endmodule // pzsp_port_chk

bind pzsp_port pzsp_port_chk i_pzsp_port_chk (.clk, .rst_n, .clkEnN, .loadAdvanceN, .chipSelAN,
    .chipSelB, .chipSelCN, .writeEnN, .outEnN, .sleepReq, .dataOut, .dataOe, .sleeping, .awake);

// file: verification/pzsp_ctrl_model.sv
`timescale 1ns/1ns
module pzsp_ctrl_model
    import pzsp_pkg::*;
(
    input  wire logic              clk,
    output logic                   clkEnN,
    output logic                   loadAdvanceN,
    output logic                   chipSelAN,
    output logic                   chipSelB,
    output logic                   chipSelCN,
    output logic                   writeEnN,
    output logic      [LANES-1:0]  byteWriteN,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] dataIn,
    output logic                   sleepReq
);
    logic [DATA_W-1:0] pendD [2];
    logic [1:0]        pendV;
    logic              wrB;

    // start deselected, sleep held low in normal work
    initial begin
        {clkEnN, loadAdvanceN, chipSelAN, chipSelB, chipSelCN, writeEnN} = 6'h0b;
        byteWriteN = 4'hf;
        addr = 19'h00000;
        dataIn = 36'h000000000;
        sleepReq = 1'b0;
        pendV = 2'h0;
        wrB = 1'b0;
    end

    // k: 0/5/6 deselect, 1 read, 2 write, 3 advance, 4 ignored edge
    task automatic beat(input logic [2:0] k, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [LANES-1:0] bw);
        @(posedge clk);
        #1;
        clkEnN       = (k == 3'h4);
        loadAdvanceN = (k == 3'h3);
        chipSelAN    = (k == 3'h0);
        chipSelB     = (k != 3'h5);
        chipSelCN    = (k == 3'h6);
        writeEnN     = (k != 3'h2);
        byteWriteN   = bw;
        addr         = (k == 3'h4) ? ~addr : a;
        if (k == 3'h4) begin
            dataIn = ~dataIn; // garbage, never the old value
        end else begin
            // late data: queued two run edges ago
            dataIn   = pendV[1] ? pendD[1] : ~dataIn;
            pendD[1] = pendD[0];
            pendV[1] = pendV[0];
            wrB      = (k == 3'h2) || (k == 3'h3 && wrB);
            pendD[0] = d;
            pendV[0] = wrB;
        end
    endtask
endmodule // pzsp_ctrl_model

// file: verification/tb.sv
`timescale 1ns/1ns
module tb;
    import pzsp_pkg::*;
    logic              clk, rst_n, outEnN, burstOrderSel;
    logic              clkEnN, loadAdvanceN, chipSelAN, chipSelB, chipSelCN, writeEnN, sleepReq;
    logic              dataOe, sleeping, awake;
    logic [LANES-1:0]  byteWriteN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dataIn, dataOut;
    logic [DATA_W-1:0] ex [2];
    logic [1:0]        ev = 2'h0;
    int                error_cnt = 0;
    int                samples_checked = 0;

    pzsp_ctrl_model i_pzsp_ctrl_model (.clk, .clkEnN, .loadAdvanceN, .chipSelAN, .chipSelB,
        .chipSelCN, .writeEnN, .byteWriteN, .addr, .dataIn, .sleepReq);
    pzsp_port i_pzsp_port (.clk, .rst_n, .clkEnN, .loadAdvanceN, .chipSelAN, .chipSelB,
        .chipSelCN, .writeEnN, .byteWriteN, .outEnN, .burstOrderSel, .sleepReq, .addr,
        .dataIn, .dataOut, .dataOe, .sleeping, .awake);

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    // one beat; the answer of a read shows two run beats later
    task automatic step(input logic [2:0] k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [LANES-1:0] bw, input logic c, input logic [DATA_W-1:0] e);
        i_pzsp_ctrl_model.beat(k, a, d, bw);
        if (k != 3'h4) begin
            chk("dataOe", DATA_W'(ev[1] & ~outEnN), DATA_W'(dataOe));
            if (ev[1]) chk("dataOut", ex[1], dataOut);
            ev = {ev[0], c};
            ex[1] = ex[0];
            ex[0] = e;
        end
    endtask

    task automatic flush;
        repeat (2) step(3'h0, 19'h00000, 36'h0, 4'hf, 1'b0, 36'h0);
    endtask

    task automatic t_rw;
        step(3'h2, 19'h00100, 36'h123456789, 4'h0, 1'b0, 36'h0);
        step(3'h1, 19'h00100, 36'h0, 4'h0, 1'b1, 36'h123456789);
        step(3'h2, 19'h00200, 36'h0abcdef01, 4'h0, 1'b0, 36'h0);
        step(3'h1, 19'h00100, 36'h0, 4'h0, 1'b1, 36'h123456789);
        step(3'h1, 19'h00200, 36'h0, 4'h0, 1'b1, 36'h0abcdef01);
        flush;
    endtask

    task automatic t_lanes;
        logic [LANES-1:0]  bw [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hf};
        logic [DATA_W-1:0] e = 36'h0;
        step(3'h2, 19'h00300, 36'h0, 4'h0, 1'b0, 36'h0);
        for (int i = 0; i < 5; i++) begin
            if (i < 4) e = e | (36'h1ff << (9 * i));
            step(3'h2, 19'h00300, 36'hfffffffff, bw[i], 1'b0, 36'h0);
            step(3'h1, 19'h00300, 36'h0, 4'h0, 1'b1, e);
        end
        flush;
    endtask

    task automatic t_burst;
        logic [1:0] lo;
        step(3'h2, 19'h00400, 36'h1, 4'h0, 1'b0, 36'h0);
        for (int b = 1; b < 4; b++) step(3'h3, 19'h00000, DATA_W'(b + 1), 4'h0, 1'b0, 36'h0);
        for (int o = 0; o < 2; o++) begin
            burstOrderSel = o[0];
            repeat (2) flush; // static select needs a quiet spell
            for (int s = 0; s < 4; s++) begin
                for (int b = 0; b < 4; b++) begin
                    lo = o[0] ? (s[1:0] ^ b[1:0]) : (s[1:0] + b[1:0]);
                    step(b == 0 ? 3'h1 : 3'h3, {17'h00100, s[1:0]}, 36'h0, 4'h0, 1'b1, 36'h1 + lo);
                end
            end
        end
        burstOrderSel = 1'b0;
        flush;
    endtask

    task automatic t_desel;
        for (int k = 0; k < 3; k++) begin
            step(3'h1, 19'h00100, 36'h0, 4'h0, 1'b1, 36'h123456789);
            step(3'(k == 0 ? 0 : 4 + k), 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
            repeat (2) step(3'h3, 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
        end
    endtask

    task automatic t_freeze;
        step(3'h2, 19'h00500, 36'h0cafe0001, 4'h0, 1'b0, 36'h0);
        step(3'h4, 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
        step(3'h1, 19'h00100, 36'h0, 4'h0, 1'b1, 36'h123456789);
        repeat (2) step(3'h4, 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
        step(3'h1, 19'h00500, 36'h0, 4'h0, 1'b1, 36'h0cafe0001);
        flush;
    endtask

    task automatic t_oe;
        outEnN = 1'b1;
        step(3'h1, 19'h00100, 36'h0, 4'h0, 1'b1, 36'h123456789);
        step(3'h0, 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
        step(3'h4, 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
        outEnN = 1'b0;
        #5 chk("dataOe", 36'h1, DATA_W'(dataOe));
        outEnN = 1'b1;
        #5 chk("dataOe", 36'h0, DATA_W'(dataOe));
        outEnN = 1'b0;
        flush;
    endtask

    task automatic t_sleep;
        int n = 0;
        step(3'h1, 19'h00100, 36'h0, 4'h0, 1'b1, 36'h123456789);
        step(3'h0, 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
        step(3'h4, 19'h00100, 36'h0, 4'h0, 1'b0, 36'h0);
        chk("dataOe", 36'h1, DATA_W'(dataOe));
        chk("dataOut", ex[1], dataOut);
        ev = 2'h0; // first run edge after wake clears the driver
        i_pzsp_ctrl_model.sleepReq = 1'b1;
        i_pzsp_ctrl_model.beat(3'h4, 19'h00100, 36'h0, 4'h0);
        chk("sleeping", 36'h0, DATA_W'(sleeping));
        i_pzsp_ctrl_model.beat(3'h4, 19'h00100, 36'h0, 4'h0);
        chk("sleeping", 36'h1, DATA_W'(sleeping));
        chk("dataOe", 36'h0, DATA_W'(dataOe));
        i_pzsp_ctrl_model.beat(3'h2, 19'h00100, 36'h0, 4'h0);
        i_pzsp_ctrl_model.beat(3'h0, 19'h00100, 36'h0, 4'h0);
        i_pzsp_ctrl_model.sleepReq = 1'b0;
        i_pzsp_ctrl_model.beat(3'h0, 19'h00100, 36'h0, 4'h0);
        chk("sleeping", 36'h1, DATA_W'(sleeping));
        i_pzsp_ctrl_model.beat(3'h0, 19'h00100, 36'h0, 4'h0);
        chk("awake", 36'h0, DATA_W'(awake));
        while (awake !== 1'b1 && n < 8) begin
            i_pzsp_ctrl_model.beat(3'h0, 19'h00100, 36'h0, 4'h0);
            n++;
        end
        if (n == 8) begin
            error_cnt++;
            final_report;
        end
        chk("wake beats", 36'h2, DATA_W'(n));
        step(3'h1, 19'h00100, 36'h0, 4'h0, 1'b1, 36'h123456789);
        flush;
    endtask

    initial begin
        rst_n = 1'b0;
        outEnN = 1'b0;
        burstOrderSel = 1'b0;
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        t_rw;
        t_lanes;
        t_burst;
        t_desel;
        t_freeze;
        t_oe;
        t_sleep;
        final_report;
    end
endmodule // tb
